// [hw/dmt_ctrl.sv]
// four-channel direct memory transfer controller core
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
module dmt_ctrl #(
    parameter int NCH = dmt_pkg::NCH
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NCH-1:0] periph_trig,
    input wire logic [NCH-1:0] event_trig,
    output logic bus_req,
    input wire logic bus_gnt,
    output logic [dmt_pkg::AW-1:0] bus_addr,
    output logic bus_we,
    output logic bus_re,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    output logic [NCH-1:0] ch_done
);
    localparam int AW = dmt_pkg::AW;

    // per-channel and shared state
    logic [5:0] ctrl_q [NCH], ctrl_d [NCH];
    logic [3:0] amode_q [NCH], amode_d [NCH];
    logic [1:0] tsel_q [NCH], tsel_d [NCH];
    logic [15:0] len_q [NCH], len_d [NCH];
    logic [7:0] rep_q [NCH], rep_d [NCH];
    logic [AW-1:0] src0_q [NCH], src0_d [NCH];
    logic [AW-1:0] dst0_q [NCH], dst0_d [NCH];
    logic [AW-1:0] src_q [NCH], src_d [NCH];
    logic [AW-1:0] dst_q [NCH], dst_d [NCH];
    logic [16:0] bcnt_q [NCH], bcnt_d [NCH];
    logic [7:0] rcnt_q [NCH], rcnt_d [NCH];
    logic [NCH-1:0] pend_q, pend_d, done_q, done_d, err_q, err_d;
    logic rr_mode_q, rr_mode_d;
    logic [1:0] last_q, last_d, cur_q, cur_d;
    logic [3:0] beat_q, beat_d;
    logic [7:0] data_q, data_d;
    dmt_pkg::dmt_state_t st_q, st_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NCH-1:0] trig_s1_q, trig_s2_q, ev_s1_q, ev_s2_q;

    // next address by mode
    function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic [1:0] m);
        unique case (m)
            dmt_pkg::AM_INC: step = a + AW'(1);
            dmt_pkg::AM_DEC: step = a - AW'(1);
            default: step = a;
        endcase
    endfunction : step

    // forbidden: flash above ram top, or any write into eeprom
    function automatic logic bad_acc(input logic [AW-1:0] a, input logic wr);
        bad_acc = (a > dmt_pkg::RAM_TOP) ||
                  (wr && a >= dmt_pkg::EE_BASE && a <= dmt_pkg::EE_TOP);
    endfunction : bad_acc

    // refused access is decoded before the request, so no beat ever reaches the bus
    logic acc_bad;
    assign acc_bad = bad_acc(src_q[cur_q], 1'b0) || bad_acc(dst_q[cur_q], 1'b1);

    // pin triggers come from other blocks' pads; two flops first
    always_ff @(posedge core_clk) begin
        trig_s1_q <= periph_trig;
        trig_s2_q <= trig_s1_q;
        ev_s1_q <= event_trig;
        ev_s2_q <= ev_s1_q;
    end

    // arbitration: fixed ch0-first, or round robin after last served
    logic [NCH-1:0] ready;
    logic [1:0] pick;
    logic found;
    always_comb begin
        ready = '0;
        pick = 2'h0;
        found = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            ready[c] = ctrl_q[c][dmt_pkg::C_EN] && pend_q[c];
        end
        for (int k = 0; k < NCH; k++) begin
            logic [1:0] c;
            c = rr_mode_q ? 2'(last_q + 2'(k + 1)) : 2'(k);
            if (!found && ready[c]) begin
                found = 1'b1;
                pick = c;
            end
        end
    end

    // register writes, triggers and the transfer sequencer
    always_comb begin
        logic [1:0] ch;
        logic [1:0] par;
        logic [3:0] blen;
        logic [NCH-1:0] dset, eset;
        ch = reg_addr[5:4];
        par = cur_q ^ 2'h1;
        blen = 4'h1 << ctrl_q[cur_q][dmt_pkg::C_BURST +: 2];
        dset = '0;
        eset = '0;
        ctrl_d = ctrl_q; amode_d = amode_q; tsel_d = tsel_q; len_d = len_q;
        rep_d = rep_q; src0_d = src0_q; dst0_d = dst0_q; src_d = src_q;
        dst_d = dst_q; bcnt_d = bcnt_q; rcnt_d = rcnt_q; pend_d = pend_q;
        done_d = done_q; err_d = err_q; rr_mode_d = rr_mode_q; last_d = last_q;
        cur_d = cur_q; beat_d = beat_q; data_d = data_q; st_d = st_q;
        rdata_d = 32'h0000_0000;
        // hardware triggers, per-channel source select
        for (int c = 0; c < NCH; c++) begin
            if ((tsel_q[c] == dmt_pkg::TS_PERIPH && trig_s2_q[c]) ||
                (tsel_q[c] == dmt_pkg::TS_EVENT && ev_s2_q[c])) begin
                pend_d[c] = 1'b1;
            end
        end
        // sequencer; core has bus priority whenever grant is low
        unique case (st_q)
            dmt_pkg::ST_IDLE: begin
                if (found) begin
                    cur_d = pick;
                    beat_d = 4'h0;
                    st_d = dmt_pkg::ST_RD;
                end
            end
            dmt_pkg::ST_RD: begin
                if (acc_bad) begin
                    err_d[cur_q] = 1'b1;
                    eset[cur_q] = 1'b1;
                    ctrl_d[cur_q][dmt_pkg::C_EN] = 1'b0;
                    pend_d[cur_q] = 1'b0;
                    st_d = dmt_pkg::ST_IDLE;
                end else if (bus_gnt) begin
                    data_d = bus_rdata;
                    st_d = dmt_pkg::ST_WR;
                end
            end
            dmt_pkg::ST_WR: begin
                if (bus_gnt) begin
                    src_d[cur_q] = step(src_q[cur_q], amode_q[cur_q][1:0]);
                    dst_d[cur_q] = step(dst_q[cur_q], amode_q[cur_q][3:2]);
                    bcnt_d[cur_q] = bcnt_q[cur_q] - 17'h1;
                    beat_d = beat_q + 4'h1;
                    if (bcnt_q[cur_q] == 17'h1) begin
                        st_d = dmt_pkg::ST_END;
                    end else if (beat_q + 4'h1 == blen) begin
                        pend_d[cur_q] = 1'b0; // one burst per trigger
                        last_d = cur_q;
                        st_d = dmt_pkg::ST_IDLE;
                    end else begin
                        st_d = dmt_pkg::ST_RD;
                    end
                end
            end
            dmt_pkg::ST_END: begin
                last_d = cur_q;
                pend_d[cur_q] = 1'b0;
                // reload block length; repeat zero means forever
                bcnt_d[cur_q] = (len_q[cur_q] == 16'h0) ? 17'h10000 : {1'b0, len_q[cur_q]};
                if (rep_q[cur_q] == 8'h0 || rcnt_q[cur_q] > 8'h1) begin
                    if (rep_q[cur_q] != 8'h0) begin
                        rcnt_d[cur_q] = rcnt_q[cur_q] - 8'h1;
                    end
                end else begin
                    done_d[cur_q] = 1'b1;
                    dset[cur_q] = 1'b1;
                    rcnt_d[cur_q] = rep_q[cur_q];
                    if (ctrl_q[cur_q][dmt_pkg::C_RELOAD]) begin
                        src_d[cur_q] = src0_q[cur_q];
                        dst_d[cur_q] = dst0_q[cur_q];
                    end
                    if (ctrl_q[cur_q][dmt_pkg::C_LINK]) begin
                        ctrl_d[cur_q][dmt_pkg::C_EN] = 1'b0;
                        ctrl_d[par][dmt_pkg::C_EN] = 1'b1;
                        pend_d[par] = 1'b1;
                    end else begin
                        ctrl_d[cur_q][dmt_pkg::C_EN] = 1'b0;
                    end
                end
                st_d = dmt_pkg::ST_IDLE;
            end
            default: st_d = dmt_pkg::ST_IDLE;
        endcase
        // software writes; set by hardware above wins over a status clear
        if (reg_wr) begin
            if (reg_addr == dmt_pkg::R_PRIO) begin
                rr_mode_d = reg_wdata[0];
            end else if (reg_addr == dmt_pkg::R_SWTRIG) begin
                pend_d = pend_d | reg_wdata[NCH-1:0];
            end else if (reg_addr < 8'(NCH) * dmt_pkg::CH_STRIDE) begin
                unique case (reg_addr[3:0])
                    dmt_pkg::R_CTRL: ctrl_d[ch] = reg_wdata[5:0];
                    dmt_pkg::R_ADDRMODE: amode_d[ch] = reg_wdata[3:0];
                    dmt_pkg::R_TRIG: tsel_d[ch] = reg_wdata[1:0];
                    dmt_pkg::R_LEN: begin
                        len_d[ch] = reg_wdata[15:0];
                        bcnt_d[ch] = (reg_wdata[15:0] == 16'h0) ? 17'h10000 :
                                     {1'b0, reg_wdata[15:0]};
                    end
                    dmt_pkg::R_REP: begin
                        rep_d[ch] = reg_wdata[7:0];
                        rcnt_d[ch] = reg_wdata[7:0];
                    end
                    dmt_pkg::R_SRC: begin
                        src0_d[ch] = reg_wdata[AW-1:0];
                        src_d[ch] = reg_wdata[AW-1:0];
                    end
                    dmt_pkg::R_DST: begin
                        dst0_d[ch] = reg_wdata[AW-1:0];
                        dst_d[ch] = reg_wdata[AW-1:0];
                    end
                    dmt_pkg::R_STAT: begin
                        // a flag set in this very cycle survives the clear
                        done_d[ch] = (done_q[ch] & ~reg_wdata[dmt_pkg::S_DONE]) | dset[ch];
                        err_d[ch] = (err_q[ch] & ~reg_wdata[dmt_pkg::S_ERR]) | eset[ch];
                    end
                    default: ;
                endcase
            end
        end
        // register reads; unmapped read as zero
        if (reg_rd) begin
            if (reg_addr == dmt_pkg::R_PRIO) begin
                rdata_d = {31'h0, rr_mode_q};
            end else if (reg_addr < 8'(NCH) * dmt_pkg::CH_STRIDE) begin
                unique case (reg_addr[3:0])
                    dmt_pkg::R_CTRL: rdata_d = {26'h0, ctrl_q[ch]};
                    dmt_pkg::R_ADDRMODE: rdata_d = {28'h0, amode_q[ch]};
                    dmt_pkg::R_TRIG: rdata_d = {30'h0, tsel_q[ch]};
                    dmt_pkg::R_LEN: rdata_d = {16'h0, len_q[ch]};
                    dmt_pkg::R_REP: rdata_d = {24'h0, rcnt_q[ch]};
                    dmt_pkg::R_SRC: rdata_d = {8'h0, src_q[ch]};
                    dmt_pkg::R_DST: rdata_d = {8'h0, dst_q[ch]};
                    dmt_pkg::R_STAT: rdata_d = {29'h0, (st_q != dmt_pkg::ST_IDLE) &&
                                      (cur_q == ch), err_q[ch], done_q[ch]};
                    default: rdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // register all state except the trigger synchronizers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int c = 0; c < NCH; c++) begin
                ctrl_q[c] <= '0; amode_q[c] <= '0; tsel_q[c] <= dmt_pkg::TS_SW;
                len_q[c] <= dmt_pkg::LEN_RST; rep_q[c] <= dmt_pkg::REP_RST;
                src0_q[c] <= dmt_pkg::ADDR_RST; dst0_q[c] <= dmt_pkg::ADDR_RST;
                src_q[c] <= dmt_pkg::ADDR_RST; dst_q[c] <= dmt_pkg::ADDR_RST;
                bcnt_q[c] <= 17'h10000; rcnt_q[c] <= dmt_pkg::REP_RST;
            end
            pend_q <= '0; done_q <= '0; err_q <= '0; rr_mode_q <= 1'b0;
            last_q <= 2'h0; cur_q <= 2'h0; beat_q <= 4'h0; data_q <= 8'h00;
            st_q <= dmt_pkg::ST_IDLE; rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d; amode_q <= amode_d; tsel_q <= tsel_d; len_q <= len_d;
            rep_q <= rep_d; src0_q <= src0_d; dst0_q <= dst0_d; src_q <= src_d;
            dst_q <= dst_d; bcnt_q <= bcnt_d; rcnt_q <= rcnt_d; pend_q <= pend_d;
            done_q <= done_d; err_q <= err_d; rr_mode_q <= rr_mode_d; last_q <= last_d;
            cur_q <= cur_d; beat_q <= beat_d; data_q <= data_d; st_q <= st_d;
            rdata_q <= rdata_d;
        end
    end

    // shared data bus master side; any region (i/o, ram, eeprom read) may be reached
    always_comb begin
        bus_req = ((st_q == dmt_pkg::ST_RD) && !acc_bad) || (st_q == dmt_pkg::ST_WR);
        bus_re = (st_q == dmt_pkg::ST_RD) && !acc_bad && bus_gnt;
        bus_we = (st_q == dmt_pkg::ST_WR) && bus_gnt;
        bus_addr = (st_q == dmt_pkg::ST_WR) ? dst_q[cur_q] : src_q[cur_q];
    end
    assign bus_wdata = data_q;
    assign reg_rdata = rdata_q;
    assign ch_done = done_q;
endmodule : dmt_ctrl

// [hw/dmt_pkg.sv]
// package for the four-channel direct memory transfer controller
// Function
// - four channels, each with its own independent configuration registers
// - block length programmable from 1 byte to 64K bytes
// - repeat counter reruns block, total transaction up to 16M bytes
// - source and destination address modes independently increment, decrement or fixed
// - reload restores original addresses when a transaction finishes
// - burst size of 1, 2, 4 or 8 bytes selectable
// - channels arbitrated by software-programmable priority scheme
// - reads and writes use the shared processor data bus
// - triggers from peripherals, event channels or software, per-channel selection
// - two channels linkable, partner takes over on finish, alternating both ways
// - may read EEPROM region, never write it, never access program flash
// - every peripheral I/O register is addressable
// - memory and peripheral in any combination of source and destination
// - bus shared with core under safe deterministic priority
package dmt_pkg;
    localparam int NCH = 4;
    localparam int AW = 24;
    // per-channel register offsets: channel base = ch * CH_STRIDE
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] R_CTRL = 4'h0;
    localparam logic [3:0] R_ADDRMODE = 4'h1;
    localparam logic [3:0] R_TRIG = 4'h2;
    localparam logic [3:0] R_LEN = 4'h3;
    localparam logic [3:0] R_REP = 4'h4;
    localparam logic [3:0] R_SRC = 4'h5;
    localparam logic [3:0] R_DST = 4'h6;
    localparam logic [3:0] R_STAT = 4'h7;
    // global registers
    localparam logic [7:0] R_PRIO = 8'h40;
    localparam logic [7:0] R_SWTRIG = 8'h41;
    // ctrl fields
    localparam int C_EN = 0;
    localparam int C_RELOAD = 1;
    localparam int C_LINK = 2;
    localparam int C_BURST = 3; // two bits
    // address mode codes
    localparam logic [1:0] AM_FIXED = 2'h0;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;
    // trigger source codes
    localparam logic [1:0] TS_SW = 2'h0;
    localparam logic [1:0] TS_PERIPH = 2'h1;
    localparam logic [1:0] TS_EVENT = 2'h2;
    // status fields
    localparam int S_DONE = 0;
    localparam int S_ERR = 1;
    localparam int S_BUSY = 2;
    // data-space regions
    localparam logic [AW-1:0] IO_TOP = 24'h000fff;
    localparam logic [AW-1:0] EE_BASE = 24'h001000;
    localparam logic [AW-1:0] EE_TOP = 24'h001fff;
    localparam logic [AW-1:0] RAM_TOP = 24'h7fffff;
    localparam logic [AW-1:0] ADDR_RST = 24'h000000;
    localparam logic [15:0] LEN_RST = 16'h0000;
    localparam logic [7:0] REP_RST = 8'h00;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RD = 4'b0010,
        ST_WR = 4'b0100,
        ST_END = 4'b1000
    } dmt_state_t;
endpackage : dmt_pkg

// [tb/dmt_ctrl_assertions.sv]
// concurrent checks on the transfer controller ports, bound into every instance
`timescale 1ns/10ps
module dmt_ctrl_checker #(
    parameter int NCH = dmt_pkg::NCH
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic bus_req,
    input wire logic bus_gnt,
    input wire logic [dmt_pkg::AW-1:0] bus_addr,
    input wire logic bus_we,
    input wire logic bus_re,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic [NCH-1:0] ch_done
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    // every beat on the shared bus is a read or a write, never both
    a_one_beat_kind: assert property (!(bus_re && bus_we))
        else $error("read and write beat in one cycle");
    // the core owns the bus unless it grants it to a requesting controller
    a_beat_needs_gnt: assert property ((bus_re || bus_we) |-> (bus_gnt && bus_req))
        else $error("bus beat without request and grant");
    // a refused request must wait with a steady address
    a_req_holds: assert property (bus_req && !bus_gnt |=> bus_req && $stable(bus_addr))
        else $error("request dropped or address moved while waiting");
    a_no_flash: assert property ((bus_re || bus_we) |-> bus_addr <= dmt_pkg::RAM_TOP)
        else $error("bus beat into program flash space");
    a_no_ee_write: assert property (bus_we |-> (bus_addr < dmt_pkg::EE_BASE
        || bus_addr > dmt_pkg::EE_TOP))
        else $error("write beat into eeprom space");
    // a read beat is followed by its write beat, which goes out as soon as granted
    a_read_then_write: assert property (bus_re ##1 bus_gnt |-> bus_we && !bus_re)
        else $error("read beat not followed by write beat");
    a_write_carries: assert property (bus_re ##1 bus_we |-> bus_wdata == $past(bus_rdata))
        else $error("written byte differs from the byte read");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
    a_reset_idle: assert property ($fell(srst) |-> !bus_req && ch_done == '0)
        else $error("controller busy right after reset");

    c_read_beat: cover property (bus_re);
    c_stalled_req: cover property (bus_req && !bus_gnt ##1 bus_gnt);
    c_done_seen: cover property ($rose(ch_done[0]));
endmodule : dmt_ctrl_checker

bind dmt_ctrl dmt_ctrl_checker #(.NCH(NCH)) i_dmt_ctrl_checker (.core_clk(core_clk),
    .srst(srst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req),
    .bus_gnt(bus_gnt), .bus_addr(bus_addr), .bus_we(bus_we), .bus_re(bus_re),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ch_done(ch_done));

// [tb/dmt_mem_model.sv]
// shared data bus partner: byte memory behind a core-side arbiter
`timescale 1ns/10ps
module dmt_mem_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic bus_req,
    output logic bus_gnt,
    input wire logic [dmt_pkg::AW-1:0] bus_addr,
    input wire logic bus_re,
    input wire logic bus_we,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output int wr_count
);
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    logic core_turn_q = 1'b0;
    int cnt = 0;

    // only the low address byte decodes, so regions alias onto one small array
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    // in slow mode the core takes every other cycle and the controller must wait
    always @(posedge core_clk) core_turn_q <= slow & ~core_turn_q;
    assign bus_gnt = bus_req & ~core_turn_q;
    // a released data line shows the inverse of the last byte, never a stale match
    assign bus_rdata = bus_re ? mem[bus_addr[7:0]] : ~last_q;
    assign wr_count = cnt;
    always @(posedge core_clk) begin
        if (bus_re) last_q <= mem[bus_addr[7:0]];
        if (bus_we) begin
            mem[bus_addr[7:0]] <= bus_wdata;
            cnt <= cnt + 1;
        end
    end
endmodule : dmt_mem_model

// [tb/test_four_channel_dma_controller.sv]
// self-checking bench for the four-channel transfer controller
`timescale 1ns/10ps
module test_four_channel_dma_controller;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rd_val;
    logic [3:0] periph_trig = 4'h0;
    logic [3:0] event_trig = 4'h0;
    logic bus_req, bus_gnt, bus_we, bus_re;
    logic slow = 1'b0;
    logic [dmt_pkg::AW-1:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    logic [3:0] ch_done;
    int failures = 0, samples_checked = 0, base;

    dmt_ctrl i_dmt_ctrl (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .periph_trig(periph_trig), .event_trig(event_trig), .bus_req(bus_req),
        .bus_gnt(bus_gnt), .bus_addr(bus_addr), .bus_we(bus_we), .bus_re(bus_re),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ch_done(ch_done));
    dmt_mem_model i_dmt_mem_model (.core_clk(core_clk), .slow(slow), .bus_req(bus_req),
        .bus_gnt(bus_gnt), .bus_addr(bus_addr), .bus_re(bus_re), .bus_we(bus_we),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .wr_count());

    always #20 core_clk = ~core_clk;

    function automatic logic [7:0] ra(input int c, input logic [3:0] off);
        return {c[3:0], off};
    endfunction : ra
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cfg(input int c, input logic [31:0] am, ts, ln, rp, s, d, ct);
        wr(ra(c, dmt_pkg::R_ADDRMODE), am);
        wr(ra(c, dmt_pkg::R_TRIG), ts);
        wr(ra(c, dmt_pkg::R_LEN), ln);
        wr(ra(c, dmt_pkg::R_REP), rp);
        wr(ra(c, dmt_pkg::R_SRC), s);
        wr(ra(c, dmt_pkg::R_DST), d);
        wr(ra(c, dmt_pkg::R_CTRL), ct);
    endtask : cfg
    // bounded poll of a status bit, then one comparison on it
    task automatic poll(input int c, input int b);
        int n;
        n = 0;
        rd(ra(c, dmt_pkg::R_STAT));
        while (rd_val[b] !== 1'b1 && n < 300) begin
            rd(ra(c, dmt_pkg::R_STAT));
            n++;
        end
        chk(32'(rd_val[b]), 32'h1);
        @(posedge core_clk);
    endtask : poll
    task automatic complete_run;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        complete_run;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            rd(ra(c, dmt_pkg::R_CTRL));
            chk(rd_val, 32'h0);
            wr(ra(c, dmt_pkg::R_LEN), 32'(c + 5));
        end
        for (int c = 0; c < 4; c++) begin
            rd(ra(c, dmt_pkg::R_LEN));
            chk(rd_val, 32'(c + 5));
        end
        rd(8'h80);
        chk(rd_val, 32'h0);
        wr(dmt_pkg::R_PRIO, 32'h1);
        rd(dmt_pkg::R_PRIO);
        chk(rd_val, 32'h1);
        // eeprom to ram, both incrementing, bursts of two, reload on
        cfg(0, 32'h5, 32'h1, 32'h4, 32'h1, 32'h001010, 32'h002040, 32'h0b);
        periph_trig[0] <= 1'b1;
        poll(0, dmt_pkg::S_DONE);
        periph_trig[0] <= 1'b0;
        chk(32'(ch_done[0]), 32'h1);
        for (int i = 0; i < 4; i++) chk(32'(i_dmt_mem_model.mem[8'h40 + i]), 32'((8'h10 + i) ^ 8'h5a));
        rd(ra(0, dmt_pkg::R_SRC));
        chk(rd_val, 32'h001010);
        rd(ra(0, dmt_pkg::R_CTRL));
        chk(32'(rd_val[dmt_pkg::C_EN]), 32'h0);
        // decrementing source into one fixed i/o register on an event trigger
        cfg(1, 32'h2, 32'h2, 32'h3, 32'h1, 32'h002012, 32'h000020, 32'h01);
        event_trig[1] <= 1'b1;
        poll(1, dmt_pkg::S_DONE);
        event_trig[1] <= 1'b0;
        chk(32'(i_dmt_mem_model.mem[8'h20]), 32'(8'h10 ^ 8'h5a));
        // single byte started by software
        cfg(2, 32'h5, 32'h0, 32'h1, 32'h1, 32'h002030, 32'h002050, 32'h01);
        wr(dmt_pkg::R_SWTRIG, 32'h4);
        poll(2, dmt_pkg::S_DONE);
        chk(32'(i_dmt_mem_model.mem[8'h50]), 32'(8'h30 ^ 8'h5a));
        // repeated block while the core steals every other bus cycle
        slow <= 1'b1;
        base = i_dmt_mem_model.wr_count;
        cfg(3, 32'h5, 32'h1, 32'h2, 32'h3, 32'h002060, 32'h002070, 32'h09);
        periph_trig[3] <= 1'b1;
        poll(3, dmt_pkg::S_DONE);
        periph_trig[3] <= 1'b0;
        slow <= 1'b0;
        chk(32'(i_dmt_mem_model.wr_count - base), 32'd6);
        // eeprom write, then a flash read: both refused without any bus write
        for (int k = 0; k < 2; k++) begin
            wr(ra(2, dmt_pkg::R_STAT), 32'h7);
            base = i_dmt_mem_model.wr_count;
            cfg(2, 32'h5, 32'h0, 32'h1, 32'h1, k ? 32'h800000 : 32'h002030,
                k ? 32'h002050 : 32'h001000, 32'h01);
            wr(dmt_pkg::R_SWTRIG, 32'h4);
            poll(2, dmt_pkg::S_ERR);
            chk(32'(i_dmt_mem_model.wr_count - base), 32'd0);
            rd(ra(2, dmt_pkg::R_CTRL));
            chk(32'(rd_val[dmt_pkg::C_EN]), 32'h0);
            wr(ra(2, dmt_pkg::R_STAT), 32'h2);
            rd(ra(2, dmt_pkg::R_STAT));
            chk(32'(rd_val[dmt_pkg::S_ERR]), 32'h0);
        end
        // linked pair: channel 2 ends and hands over to channel 3, which then stops
        wr(ra(3, dmt_pkg::R_STAT), 32'h7);
        cfg(3, 32'h5, 32'h0, 32'h1, 32'h1, 32'h002031, 32'h002081, 32'h00);
        cfg(2, 32'h5, 32'h0, 32'h1, 32'h1, 32'h002030, 32'h002080, 32'h05);
        wr(dmt_pkg::R_SWTRIG, 32'h4);
        poll(3, dmt_pkg::S_DONE);
        chk(32'(i_dmt_mem_model.mem[8'h80]), 32'(8'h30 ^ 8'h5a));
        chk(32'(i_dmt_mem_model.mem[8'h81]), 32'(8'h31 ^ 8'h5a));
        rd(ra(2, dmt_pkg::R_CTRL));
        chk(32'(rd_val[dmt_pkg::C_EN]), 32'h0);
        rd(ra(3, dmt_pkg::R_CTRL));
        chk(32'(rd_val[dmt_pkg::C_EN]), 32'h0);
        complete_run;
    end
endmodule : test_four_channel_dma_controller
